// ===== gdfs_regs.vh
/*
 * constants for the gate driver fault supervisor: register offsets,
 * field positions, reset values and timing counts.
 * assumes a 100 MHz core clock and a 24-bit host serial frame.
 */
// Summary of operation
// - gate voltage monitor fault latches and blocks gate drive until cleared
// - gate voltage fault mask bit at zero stops that fault blocking drive
// - short circuit latches, blocks drive, cannot be masked, only clear re-enables
// - short circuit threshold and filter time are programmable
// - dead time always enforced; violating pwm inputs set a fault flag
// - dead time programmable; dead time fault maskable
// - overcurrent latches without blocking drive, unmaskable, held until cleared
// - overcurrent threshold and filter time are programmable
// - one die powered without the other, before both were ever up together, sets a sticky watchdog fault
// - frame error when clocks per select frame are not a multiple of 24
// - frame error when the received crc does not match the frame
// - host keeps 19 us between frames; shorter gap sets frame error
// - frame error also cleared by running the built-in self test
// - frame error may set at power-up with a floating select line
// - isolated supply overvoltage latches a flag and blocks gate drive
// - logic supply undervoltage freezes the serial response buffer
// - response echoes the command address; host compares to spot freezing
// - regulator and reference undervoltage latch as sticky flags
// - unpowered isolated side keeps its status and measurements unchanged
// - setup mode bit at one keeps gate drive disabled
// - fail safe enable input low keeps gate drive disabled
`ifndef GDFS_REGS_VH
`define GDFS_REGS_VH

// ======================================================================
// register offsets
`define OFS_STATUS_A   8'h00
`define OFS_STATUS_B   8'h04
`define OFS_MASK_B     8'h08
`define OFS_MODE_B     8'h0c
`define OFS_OC_SETUP   8'h10
`define OFS_SC_SETUP   8'h14
`define OFS_DT_SETUP   8'h18
`define OFS_GM_SETUP   8'h1c
`define OFS_MEASURE    8'h20

// ======================================================================
// field positions
`define A_SC      0
`define A_OC      1
`define A_OV      2
`define A_REGUV   3
`define B_GVF     0
`define B_DT      1
`define B_WDOG    2
`define B_SFE     3
`define B_REFUV   4
`define M_GVF     0
`define M_DT      1
`define MODE_SETUP 0
`define MODE_BIST  1

// ======================================================================
// reset values
`define MASK_B_RST 2'h3
`define SETUP_RST  8'hff
`define DT_RST     8'h10
`define GM_RST     8'h20

// ======================================================================
// timing
`define CLK_PERIOD_NS 10
`define FRAME_GAP_NS  19000
`define FRAME_GAP_CYC ((`FRAME_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FRAME_BITS    24
`define CRC_POLY      8'h07

`endif

// ===== gate_driver_fault_supervisor.v
/*
 * fault supervision, gate drive gating, dead time enforcement and
 * serial frame checking for a single gate driver channel.
 * assumes pins are asynchronous to core_clk and are synchronised here;
 * current_sample comes from logic on core_clk.
 */
// Implementation choices: strobed register access and the placing of the registers.
`include "gdfs_regs.vh"
`default_nettype none

module gate_driver_fault_supervisor #(
    parameter GAP_W = 12
) (
    input  wire        core_clk,
    input  wire        rst,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    input  wire        sclk,
    input  wire        chip_select_n,
    input  wire        mosi,
    output reg         miso,
    output wire        miso_oe,
    input  wire        pwm_high_in,
    input  wire        pwm_low_in,
    output reg         gate_high_out,
    output reg         gate_low_out,
    input  wire        fail_safe_enable_n,
    input  wire        gate_voltage_ok,
    input  wire [7:0]  current_sample,
    input  wire        overvoltage_in,
    input  wire        regulator_uv_in,
    input  wire        reference_uv_in,
    input  wire        logic_supply_undervoltage,
    input  wire        hv_side_powered,
    input  wire        die_a_powered,
    input  wire        die_b_powered
);

// ======================================================================
// synchronisers
localparam NSYNC = 14;
// select pin idles high, so no false select edge follows reset
localparam [NSYNC-1:0] SYNC_IDLE = 14'h1000;
wire [NSYNC-1:0] pin_raw = {sclk, chip_select_n, mosi, pwm_high_in,
    pwm_low_in, fail_safe_enable_n, gate_voltage_ok, overvoltage_in,
    regulator_uv_in, reference_uv_in, logic_supply_undervoltage,
    hv_side_powered, die_a_powered, die_b_powered};
reg  [NSYNC-1:0] sync_a;
reg  [NSYNC-1:0] sync_b;
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        sync_a <= SYNC_IDLE;
        sync_b <= SYNC_IDLE;
    end else begin
        sync_a <= pin_raw;
        sync_b <= sync_a;
    end
end
wire s_sclk  = sync_b[13];
wire s_cs_n  = sync_b[12];
wire s_mosi  = sync_b[11];
wire s_pwm_h = sync_b[10];
wire s_pwm_l = sync_b[9];
wire s_fsen  = sync_b[8];
wire s_gv_ok = sync_b[7];
wire s_ov    = sync_b[6];
wire s_reguv = sync_b[5];
wire s_refuv = sync_b[4];
wire s_lvuv  = sync_b[3];
wire s_hv_on = sync_b[2];
wire s_die_a = sync_b[1];
wire s_die_b = sync_b[0];

// ======================================================================
// functions
function [7:0] next_filter;
    input [7:0] cnt;
    input       over;
    begin
        if (!over)
            next_filter = 8'h00;
        else if (cnt == 8'hff)
            next_filter = cnt;
        else
            next_filter = cnt + 8'h01;
    end
endfunction

function [7:0] crc8;
    input [15:0] d;
    integer      i;
    reg   [7:0]  c;
    begin
        c = 8'h00;
        for (i = 15; i >= 0; i = i - 1) begin
            if (c[7] ^ d[i])
                c = {c[6:0], 1'b0} ^ `CRC_POLY;
            else
                c = {c[6:0], 1'b0};
        end
        crc8 = c;
    end
endfunction

// ======================================================================
// software registers
reg  [3:0]  status_a;
reg  [4:0]  status_b;
reg  [1:0]  mask_b;
reg         setup_mode;
reg         bist_run;
reg  [15:0] oc_setup;
reg  [15:0] sc_setup;
reg  [7:0]  dt_setup;
reg  [7:0]  gm_setup;
reg  [7:0]  measure;
wire [3:0]  set_a;
wire [4:0]  set_b;
wire        wr_a = reg_wr && (reg_addr == `OFS_STATUS_A);
wire        wr_b = reg_wr && (reg_addr == `OFS_STATUS_B);
wire [3:0]  clr_a = wr_a ? reg_wdata[3:0] : 4'h0;
wire [4:0]  clr_b;
assign clr_b[`B_SFE] = (wr_b && reg_wdata[`B_SFE]) || bist_run;
assign clr_b[2:0] = wr_b ? reg_wdata[2:0] : 3'h0;
assign clr_b[4]   = wr_b ? reg_wdata[4] : 1'b0;

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        status_a   <= 4'h0;
        status_b   <= 5'h00;
        mask_b     <= `MASK_B_RST;
        setup_mode <= 1'b1;
        bist_run   <= 1'b0;
        oc_setup   <= {`SETUP_RST, `SETUP_RST};
        sc_setup   <= {`SETUP_RST, `SETUP_RST};
        dt_setup   <= `DT_RST;
        gm_setup   <= `GM_RST;
        measure    <= 8'h00;
    end else begin
        // set wins over a simultaneous clear
        status_a <= (status_a & ~clr_a) | set_a;
        status_b <= (status_b & ~clr_b) | set_b;
        bist_run <= reg_wr && (reg_addr == `OFS_MODE_B) && reg_wdata[`MODE_BIST];
        if (s_hv_on)
            measure <= current_sample;
        if (reg_wr) begin
            if (reg_addr == `OFS_MASK_B)
                mask_b <= reg_wdata[1:0];
            else if (reg_addr == `OFS_MODE_B)
                setup_mode <= reg_wdata[`MODE_SETUP];
            else if (reg_addr == `OFS_OC_SETUP)
                oc_setup <= reg_wdata[15:0];
            else if (reg_addr == `OFS_SC_SETUP)
                sc_setup <= reg_wdata[15:0];
            else if (reg_addr == `OFS_DT_SETUP)
                dt_setup <= reg_wdata[7:0];
            else if (reg_addr == `OFS_GM_SETUP)
                gm_setup <= reg_wdata[7:0];
        end
    end
end

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
        if (reg_addr == `OFS_STATUS_A)
            reg_rdata <= {28'h0, status_a};
        else if (reg_addr == `OFS_STATUS_B)
            reg_rdata <= {27'h0, status_b};
        else if (reg_addr == `OFS_MASK_B)
            reg_rdata <= {30'h0, mask_b};
        else if (reg_addr == `OFS_MODE_B)
            reg_rdata <= {31'h0, setup_mode};
        else if (reg_addr == `OFS_OC_SETUP)
            reg_rdata <= {16'h0, oc_setup};
        else if (reg_addr == `OFS_SC_SETUP)
            reg_rdata <= {16'h0, sc_setup};
        else if (reg_addr == `OFS_DT_SETUP)
            reg_rdata <= {24'h0, dt_setup};
        else if (reg_addr == `OFS_GM_SETUP)
            reg_rdata <= {24'h0, gm_setup};
        else if (reg_addr == `OFS_MEASURE)
            reg_rdata <= {24'h0, measure};
        else
            reg_rdata <= 32'h0000_0000;
    end else begin
        reg_rdata <= 32'h0000_0000;
    end
end

// ======================================================================
// current detection with threshold and filter
reg  [7:0] sc_cnt;
reg  [7:0] oc_cnt;
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        sc_cnt <= 8'h00;
        oc_cnt <= 8'h00;
    end else begin
        sc_cnt <= next_filter(sc_cnt, current_sample > sc_setup[7:0]);
        oc_cnt <= next_filter(oc_cnt, current_sample > oc_setup[7:0]);
    end
end
wire sc_hit = (sc_cnt >= sc_setup[15:8]) && (current_sample > sc_setup[7:0]);
wire oc_hit = (oc_cnt >= oc_setup[15:8]) && (current_sample > oc_setup[7:0]);

// ======================================================================
// gate voltage monitor
reg  [7:0] gm_cnt;
always @(posedge core_clk or posedge rst) begin
    if (rst)
        gm_cnt <= 8'h00;
    else
        gm_cnt <= next_filter(gm_cnt, gate_high_out);
end
wire gv_hit = gate_high_out && (gm_cnt >= gm_setup) && !s_gv_ok;

// ======================================================================
// flag set terms; isolated side flags freeze when unpowered
reg  die_seen;
always @(posedge core_clk or posedge rst) begin
    if (rst)
        die_seen <= 1'b0;
    else if (s_die_a && s_die_b)
        die_seen <= 1'b1;
end
wire dt_viol;
wire sfe_set;
assign set_a[`A_SC]    = s_hv_on && sc_hit;
assign set_a[`A_OC]    = s_hv_on && oc_hit;
assign set_a[`A_OV]    = s_hv_on && s_ov;
assign set_a[`A_REGUV] = s_hv_on && s_reguv;
assign set_b[`B_GVF]   = s_hv_on && gv_hit;
assign set_b[`B_DT]    = dt_viol && mask_b[`M_DT];
assign set_b[`B_WDOG]  = !die_seen && (s_die_a ^ s_die_b);
assign set_b[`B_SFE]   = sfe_set;
assign set_b[`B_REFUV] = s_hv_on && s_refuv;

// ======================================================================
// drive enable and dead time
wire drive_block = status_a[`A_SC]
    || status_a[`A_OV]
    || (status_b[`B_GVF] && mask_b[`M_GVF])
    || setup_mode
    || !s_fsen;
reg  [7:0] dt_cnt;
reg        last_low;
wire dt_done = (dt_cnt >= dt_setup);
wire next_gate_high = !drive_block && s_pwm_h && !s_pwm_l
    && (gate_high_out || (!gate_low_out && dt_done));
wire next_gate_low = !drive_block && s_pwm_l && !s_pwm_h
    && (gate_low_out || (!gate_high_out && dt_done));
assign dt_viol = (s_pwm_h && s_pwm_l)
    || (s_pwm_h && last_low && !gate_high_out && !dt_done)
    || (s_pwm_l && !last_low && !gate_low_out && !dt_done);
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        gate_high_out <= 1'b0;
        gate_low_out  <= 1'b0;
        dt_cnt        <= 8'hff;
        last_low      <= 1'b0;
    end else begin
        gate_high_out <= next_gate_high;
        gate_low_out  <= next_gate_low;
        dt_cnt <= next_filter(dt_cnt, !gate_high_out && !gate_low_out);
        if (gate_low_out)
            last_low <= 1'b1;
        else if (gate_high_out)
            last_low <= 1'b0;
    end
end

// ======================================================================
// serial frame checker and responder
reg         sclk_d;
reg         cs_d;
reg  [4:0]  bit_cnt;
reg  [23:0] rx_word;
reg  [GAP_W-1:0] gap_cnt;
reg  [23:0] tx_shift;
reg  [23:0] resp_buf;
reg         rx_ok;
reg  [4:0]  last_addr;
wire sclk_rise = s_sclk && !sclk_d;
wire sclk_fall = !s_sclk && sclk_d;
wire cs_fall   = !s_cs_n && cs_d;
wire cs_rise   = s_cs_n && !cs_d;
wire [23:0] rx_next = {rx_word[22:0], s_mosi};
wire word_end  = !s_cs_n && sclk_rise && (bit_cnt == 5'd23);
wire crc_bad   = word_end && (crc8(rx_next[23:8]) != rx_next[7:0]);
wire len_bad   = cs_rise && (bit_cnt != 5'd0);
wire gap_bad   = cs_fall && (gap_cnt < `FRAME_GAP_CYC);
// a floating select at power-up can produce these too
assign sfe_set = crc_bad || len_bad || gap_bad;
assign miso_oe = !s_cs_n;
wire [9:0] resp_flags = {1'b0, status_b, status_a};
wire [15:0] resp_head = {1'b0, last_addr, resp_flags};

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        sclk_d    <= 1'b0;
        cs_d      <= 1'b1;
        bit_cnt   <= 5'd0;
        rx_word   <= 24'h000000;
        gap_cnt   <= {GAP_W{1'b1}};
        tx_shift  <= 24'h000000;
        resp_buf  <= 24'h000000;
        rx_ok     <= 1'b0;
        last_addr <= 5'd0;
        miso      <= 1'b0;
    end else begin
        sclk_d <= s_sclk;
        cs_d   <= s_cs_n;
        if (!s_cs_n)
            gap_cnt <= {GAP_W{1'b0}};
        else if (gap_cnt != {GAP_W{1'b1}})
            gap_cnt <= gap_cnt + {{(GAP_W-1){1'b0}}, 1'b1};
        if (cs_fall) begin
            bit_cnt  <= 5'd0;
            rx_ok    <= 1'b0;
            tx_shift <= {resp_buf[22:0], 1'b0};
            miso     <= resp_buf[23];
        end else if (!s_cs_n && sclk_rise) begin
            rx_word <= rx_next;
            if (bit_cnt == 5'd23) begin
                bit_cnt <= 5'd0;
                rx_ok   <= !crc_bad;
                if (!crc_bad)
                    last_addr <= rx_next[22:18];
            end else begin
                bit_cnt <= bit_cnt + 5'd1;
            end
        end else if (!s_cs_n && sclk_fall) begin
            miso     <= tx_shift[23];
            tx_shift <= {tx_shift[22:0], 1'b0};
        end
        if (cs_rise && rx_ok && !len_bad && !s_lvuv)
            resp_buf <= {resp_head, crc8(resp_head)};
    end
end

endmodule // gate_driver_fault_supervisor
`default_nettype wire

// ===== gdfs_assertions.sv
/*
 * port checker for gate_driver_fault_supervisor, with its bind.
 * assumes one core_clk domain, rst async active high, dead time of 8 cycles or more.
 */
`default_nettype none
module gdfs_checker (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        chip_select_n,
    input wire logic        miso_oe,
    input wire logic        pwm_high_in,
    input wire logic        fail_safe_enable_n,
    input wire logic        gate_high_out,
    input wire logic        gate_low_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================================
    // gate drive and frame select
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_setup_on;
        reg_wr && reg_addr == 8'h0c && reg_wdata[0];
    endsequence
    sequence s_fs_low;
        !fail_safe_enable_n [*4];
    endsequence
    sequence s_gates_off;
        !gate_high_out && !gate_low_out;
    endsequence
    a_failsafe_gates_off: assert property (s_fs_low |-> s_gates_off)
        else $error("gate driven while fail safe low");
    a_setup_gates_off: assert property (s_setup_on |-> ##2 s_gates_off [*8])
        else $error("gate driven in setup mode");
    a_gates_never_both: assert property (!(gate_high_out && gate_low_out))
        else $error("both gates on");
    a_dead_before_high: assert property ($rose(gate_high_out) |-> !$past(gate_low_out, 1) && !$past(gate_low_out, 8))
        else $error("high gate inside dead time");
    a_dead_before_low: assert property ($rose(gate_low_out) |-> !$past(gate_high_out, 1) && !$past(gate_high_out, 8))
        else $error("low gate inside dead time");
    a_high_needs_pwm: assert property (!pwm_high_in [*5] |-> !gate_high_out)
        else $error("high gate without pwm");
    a_idle_no_drive: assert property (chip_select_n [*5] |-> !miso_oe)
        else $error("miso driven outside frame");
    a_frame_drive: assert property (!chip_select_n [*4] |-> miso_oe)
        else $error("miso not driven in frame");
endmodule // gdfs_checker

bind gate_driver_fault_supervisor gdfs_checker u_chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .chip_select_n(chip_select_n), .miso_oe(miso_oe),
    .pwm_high_in(pwm_high_in), .fail_safe_enable_n(fail_safe_enable_n), .gate_high_out(gate_high_out),
    .gate_low_out(gate_low_out));
`default_nettype wire

// ===== gdfs_host_model.sv
/*
 * serial host model: select, clock and data of frames, 80 ns clock.
 * assumes the device samples on sclk rise and shifts on sclk fall.
 */
`default_nettype none
module gdfs_host_model (
    output logic      sclk,
    output logic      chip_select_n,
    output logic      mosi,
    input  wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk = 0;
        chip_select_n = 1;
        mosi = 0;
    end
    // ==================================================================
    // frame crc and transfer
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = (c << 1) ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction
    task automatic xfer(input logic [23:0] w, input int n, input int gap, output logic [23:0] r);
        r = 24'h0;
        #(gap + 3);
        chip_select_n = 0;
        for (int i = 0; i < n; i++) begin
            mosi = w[23 - i];
            #40 sclk = 1;
            r = {r[22:0], miso};
            #40 sclk = 0;
        end
        #40 chip_select_n = 1;
        mosi = ~mosi;
    endtask
endmodule // gdfs_host_model
`default_nettype wire

// ===== gate_driver_fault_supervisor_tb_top.sv
/*
 * self-checking bench for gate_driver_fault_supervisor.
 * assumes the host model drives the serial pins and a 100 MHz core clock.
 */
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module gate_driver_fault_supervisor_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, pwm_high_in = 0, pwm_low_in = 0;
    logic        fs_n = 1, gv_ok = 1, ov = 0, reg_uv = 0, ref_uv = 0, lsu = 0, hv = 1, die_a = 1, die_b = 0;
    logic [7:0]  reg_addr = 0, current_sample = 0;
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic        sclk, chip_select_n, mosi, miso, miso_oe, gate_high_out, gate_low_out;
    logic [23:0] r;
    int          mismatches = 0, total_checks = 0;
    logic [39:0] rv [7] = '{40'h08_0000_0003, 40'h0c_0000_0001, 40'h10_0000_ffff, 40'h14_0000_ffff,
                            40'h18_0000_0010, 40'h1c_0000_0020, 40'h3c_0000_0000};
    always #5 core_clk = ~core_clk;
    gdfs_host_model host (.sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso));
    gate_driver_fault_supervisor dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk(sclk),
        .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .pwm_high_in(pwm_high_in), .pwm_low_in(pwm_low_in), .gate_high_out(gate_high_out),
        .gate_low_out(gate_low_out), .fail_safe_enable_n(fs_n), .gate_voltage_ok(gv_ok),
        .current_sample(current_sample), .overvoltage_in(ov), .regulator_uv_in(reg_uv),
        .reference_uv_in(ref_uv), .logic_supply_undervoltage(lsu), .hv_side_powered(hv),
        .die_a_powered(die_a), .die_b_powered(die_b));
    // ==================================================================
    // access tasks
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 0;
    endtask
    task automatic chk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd   <= 1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 0;
        #1;
        `CHK(n, e, reg_rdata & m)
    endtask
    task automatic frame(input logic [4:0] a, input int n, input logic bad, input int gap);
        logic [15:0] h;
        h = {1'b0, a, 10'h0};
        host.xfer({h, host.crc8(h) ^ {7'h0, bad}}, n, gap, r);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #400us;
        mismatches++;
        give_verdict;
    end
    // ==================================================================
    // tests
    initial begin
        tick(2);
        rst <= 0;
        tick(4);
        chk("watchdog", 8'h04, 32'h4, 32'h4);
        @(posedge core_clk) die_b <= 1;
        tick(2);
        wr(8'h04, 32'h1f);
        chk("watchdog clear", 8'h04, 32'h1f, 32'h0);
        foreach (rv[i]) chk("reset value", rv[i][39:32], 32'hffffffff, rv[i][31:0]);
        @(posedge core_clk) pwm_high_in <= 1;
        tick(30);
        `CHK("setup blocks", 1'b0, gate_high_out)
        wr(8'h0c, 32'h0);
        tick(30);
        `CHK("gate on", 1'b1, gate_high_out)
        for (int k = 0; k < 2; k++) begin
            wr(8'h08, k ? 32'h1 : 32'h3);
            wr(8'h04, 32'h2);
            @(posedge core_clk) pwm_low_in <= 1;
            tick(6);
            `CHK("low held off", 1'b0, gate_low_out)
            @(posedge core_clk) pwm_low_in <= 0;
            chk("dead time flag", 8'h04, 32'h2, k ? 32'h0 : 32'h2);
        end
        wr(8'h08, 32'h3);
        tick(30);
        `CHK("high back on", 1'b1, gate_high_out)
        @(posedge core_clk) {pwm_high_in, pwm_low_in} <= 2'b01;
        tick(10);
        `CHK("low waits dead time", 1'b0, gate_low_out)
        tick(20);
        `CHK("low after dead time", 1'b1, gate_low_out)
        @(posedge core_clk) {pwm_high_in, pwm_low_in} <= 2'b10;
        @(posedge core_clk) gv_ok <= 0;
        tick(60);
        chk("gate voltage flag", 8'h04, 32'h1, 32'h1);
        `CHK("gvf blocks", 1'b0, gate_high_out)
        wr(8'h08, 32'h2);
        wr(8'h04, 32'h1);
        tick(30);
        `CHK("gvf masked", 1'b1, gate_high_out)
        @(posedge core_clk) gv_ok <= 1;
        wr(8'h08, 32'h0);
        wr(8'h04, 32'h1);
        wr(8'h14, 32'h0240);
        wr(8'h10, 32'h0220);
        @(posedge core_clk) current_sample <= 8'h80;
        tick(10);
        @(posedge core_clk) current_sample <= 8'h00;
        tick(30);
        `CHK("sc blocks unmasked", 1'b0, gate_high_out)
        chk("sc and oc flags", 8'h00, 32'h3, 32'h3);
        wr(8'h00, 32'h3);
        tick(30);
        `CHK("gate after clear", 1'b1, gate_high_out)
        @(posedge core_clk) current_sample <= 8'h30;
        tick(10);
        chk("oc only", 8'h00, 32'h3, 32'h2);
        `CHK("oc keeps drive", 1'b1, gate_high_out)
        @(posedge core_clk) hv <= 0;
        tick(2);
        @(posedge core_clk) {reg_uv, current_sample} <= {1'b1, 8'h55};
        tick(10);
        chk("frozen measurement", 8'h20, 32'hff, 32'h30);
        chk("frozen flags", 8'h00, 32'h8, 32'h0);
        @(posedge core_clk) {hv, reg_uv, current_sample} <= 10'h200;
        wr(8'h00, 32'hf);
        @(posedge core_clk) {ov, reg_uv, ref_uv} <= 3'b111;
        tick(10);
        @(posedge core_clk) {ov, reg_uv, ref_uv} <= 3'b000;
        tick(30);
        `CHK("ov blocks", 1'b0, gate_high_out)
        chk("ov and reg uv", 8'h00, 32'hf, 32'hc);
        chk("ref uv", 8'h04, 32'h10, 32'h10);
        wr(8'h00, 32'hf);
        wr(8'h04, 32'h10);
        tick(30);
        `CHK("gate after ov clear", 1'b1, gate_high_out)
        wr(8'h0c, 32'h1);
        tick(10);
        `CHK("setup blocks again", 1'b0, gate_high_out)
        wr(8'h0c, 32'h0);
        tick(30);
        @(posedge core_clk) fs_n <= 0;
        tick(6);
        `CHK("fail safe", 1'b0, gate_high_out)
        @(posedge core_clk) fs_n <= 1;
        frame(5'h05, 24, 0, 20000);
        frame(5'h09, 24, 0, 20000);
        `CHK("echoed address", 5'h05, r[22:18])
        `CHK("response crc", host.crc8(r[23:8]), r[7:0])
        chk("good frames", 8'h04, 32'h8, 32'h0);
        for (int i = 0; i < 3; i++) begin
            frame(5'h03, i ? 24 : 23, i == 1, i == 2 ? 2000 : 20000);
            tick(5);
            chk("frame error", 8'h04, 32'h8, 32'h8);
            wr(i ? 8'h04 : 8'h0c, i ? 32'h8 : 32'h2);
            chk("frame error cleared", 8'h04, 32'h8, 32'h0);
        end
        @(posedge core_clk) lsu <= 1;
        frame(5'h0a, 24, 0, 20000);
        frame(5'h0a, 24, 0, 20000);
        `CHK("frozen response", 5'h03, r[22:18])
        give_verdict;
    end
endmodule // gate_driver_fault_supervisor_tb_top
`default_nettype wire
